/* hw/snha_top.sv */
`timescale 1ns/1ps
`default_nettype none
// spi master access to external eeprom or flash
module snha_top
	import snha_pkg::*;
#(
	parameter int GPIO_N = 8,
	parameter int EE_WAIT = EE_WRITE_CYC,
	parameter int FL_WAIT = FL_WRITE_CYC
) (
	// system clock
	input wire logic clk,
	input wire logic reset,
	// link clock, divided down to the 4 MHz sck
	input wire logic link_clk,
	// configuration from config page
	input wire logic [7:0] cfg_sel_pin,
	input wire logic cfg_is_flash,
	input wire logic cfg_family_b,
	input wire logic cfg_mode3,
	// command
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_op,
	input wire logic [23:0] cmd_addr,
	input wire logic [8:0] cmd_len,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic cmd_ready,
	output logic [7:0] status_byte,
	output logic mem_protect,
	output logic [1:0] mem_block_guard,
	output logic mem_latch,
	output logic mem_busy,
	// spi pins
	output logic spi_sck,
	output logic spi_mosi,
	input wire logic spi_miso,
	output logic [GPIO_N-1:0] gpio_out
);
	typedef enum {S_IDLE, S_LATCH, S_CMD, S_ADDR, S_DATA, S_GAP, S_POLL, S_POLL_RD, S_WAIT} snha_st_t;
	typedef struct packed {
		snha_st_t st;
		snha_op_t op;
		logic [1:0] lrst;
		logic [2:0] ack_s;
		logic req;
		logic pend;
		logic [1:0] phase_n;
		logic [8:0] cnt;
		logic [23:0] addr;
		logic [7:0] txb;
		logic last;
		logic cs_n;
		logic [7:0] sel;
		logic [7:0] stat;
		logic [7:0] rd;
		logic rdv;
		logic take;
		logic polled;
		logic [31:0] tmo;
		logic ready;
	} snha_s_t;
	snha_s_t s_ff;
	snha_s_t nxt_s;
	snha_link_if lk();
	logic l_rst1_ff, l_rst2_ff, l_sck_ff, l_mosi_ff;
	logic [2:0] miso_s_ff;
	logic l_sck, l_mosi, l_act;
	logic miso_q_ff;

	// ****************************************
	// link-side shifter
	// ****************************************
	always_ff @(posedge link_clk) begin
		l_rst1_ff <= reset;
		l_rst2_ff <= l_rst1_ff;
		miso_s_ff <= {miso_s_ff[1:0], spi_miso};
		l_sck_ff <= l_sck;
		l_mosi_ff <= l_mosi;
		miso_q_ff <= (miso_s_ff[2] == miso_s_ff[1]) ? miso_s_ff[2] : miso_q_ff; // second and third agree
	end

	snha_shifter u_sh (
		.link_clk(link_clk),
		.link_reset(l_rst2_ff),
		.lk(lk),
		.sck(l_sck),
		.mosi(l_mosi),
		.miso(miso_q_ff),
		.active(l_act)
	);

	assign lk.req_tgl = s_ff.req;
	assign lk.tx_byte = s_ff.txb;
	assign lk.last = s_ff.last;
	assign lk.cpol = cfg_mode3;

	// opcode for the request by memory kind and family
	function automatic logic [7:0] op_code(input snha_op_t op, input logic fl, input logic fb);
		logic [7:0] c;
		c = DATA_READ_CMD;
		case (op)
			SNHA_OP_READ: c = DATA_READ_CMD;
			SNHA_OP_FAST_READ: c = FAST_READ_CMD;
			SNHA_OP_WRITE: c = fl ? PAGE_PROGRAM_CMD : DATA_WRITE_CMD;
			SNHA_OP_ERASE: c = PAGE_ERASE_CMD;
			SNHA_OP_REWRITE: c = fb ? FL_B_PAGE_REWRITE_CMD : FL_A_PAGE_REWRITE_CMD;
			SNHA_OP_STATUS_READ: c = (fl && !fb) ? FL_A_STATUS_READ_CMD : EE_STATUS_READ_CMD;
			SNHA_OP_STATUS_WRITE: c = STATUS_WRITE_CMD;
			SNHA_OP_IDENTITY: c = IDENTITY_READ_CMD;
			SNHA_OP_SLEEP: c = DEEP_SLEEP_CMD;
			SNHA_OP_ULTRA_SLEEP: c = ULTRA_SLEEP_CMD;
			SNHA_OP_WAKE: c = WAKE_FROM_SLEEP_CMD;
			SNHA_OP_LATCH_CLEAR: c = CLEAR_WRITE_LATCH_CMD;
			default: c = DATA_READ_CMD;
		endcase
		return c;
	endfunction

	// true when the op alters memory and needs the latch and a busy poll
	function automatic logic is_mod(input snha_op_t op);
		return op == SNHA_OP_WRITE || op == SNHA_OP_ERASE || op == SNHA_OP_REWRITE || op == SNHA_OP_STATUS_WRITE;
	endfunction

	function automatic logic has_addr(input snha_op_t op);
		return op == SNHA_OP_READ || op == SNHA_OP_FAST_READ || op == SNHA_OP_WRITE || op == SNHA_OP_ERASE ||
			op == SNHA_OP_REWRITE;
	endfunction

	// ****************************************
	// command sequencer
	// ****************************************
	always_comb begin
		logic ack_ev;
		ack_ev = 1'b0;
		nxt_s = s_ff;
		nxt_s.ack_s = {s_ff.ack_s[1:0], lk.ack_tgl};
		nxt_s.rdv = 1'b0;
		nxt_s.take = 1'b0;
		nxt_s.lrst = {s_ff.lrst[0], 1'b1};
		if (s_ff.lrst == 2'h1) begin
			nxt_s.sel = cfg_sel_pin;
		end
		if (s_ff.pend && s_ff.ack_s[2] == s_ff.req && s_ff.ack_s[2] == s_ff.ack_s[1]) begin
			ack_ev = 1'b1;
			nxt_s.pend = 1'b0;
		end
		case (s_ff.st)
			S_IDLE: begin
				nxt_s.cs_n = 1'b1;
				if (cmd_valid && s_ff.lrst[1]) begin
					nxt_s.op = snha_op_t'(cmd_op);
					nxt_s.addr = cmd_addr;
					// burst capped at one page length of 256 bytes, whatever the start address
					nxt_s.cnt = (cmd_len > 9'(PAGE_BYTES)) ? 9'(PAGE_BYTES) : cmd_len;
					nxt_s.cs_n = 1'b0;
					nxt_s.pend = 1'b1;
					nxt_s.req = ~s_ff.req;
					nxt_s.last = 1'b0;
					if (is_mod(snha_op_t'(cmd_op))) begin
						nxt_s.txb = SET_WRITE_LATCH_CMD;
						nxt_s.st = S_LATCH;
					end else begin
						nxt_s.txb = op_code(snha_op_t'(cmd_op), cfg_is_flash, cfg_family_b);
						nxt_s.st = S_CMD;
					end
				end
			end
			S_LATCH: if (ack_ev) begin
				nxt_s.cs_n = 1'b1; // latch command ends with select release
				nxt_s.st = S_GAP;
			end
			S_GAP: begin
				nxt_s.cs_n = 1'b0;
				nxt_s.pend = 1'b1;
				nxt_s.req = ~s_ff.req;
				nxt_s.txb = op_code(s_ff.op, cfg_is_flash, cfg_family_b);
				nxt_s.st = S_CMD;
			end
			S_CMD: if (ack_ev) begin
				nxt_s.phase_n = 2'h0;
				nxt_s.pend = 1'b1;
				nxt_s.req = ~s_ff.req;
				if (has_addr(s_ff.op)) begin
					nxt_s.txb = cfg_is_flash ? s_ff.addr[23:16] : s_ff.addr[15:8];
					nxt_s.phase_n = cfg_is_flash ? 2'h0 : 2'h1;
					nxt_s.st = S_ADDR;
				end else if (s_ff.op == SNHA_OP_STATUS_WRITE || s_ff.cnt != 9'h000 &&
					(s_ff.op == SNHA_OP_STATUS_READ || s_ff.op == SNHA_OP_IDENTITY)) begin
					nxt_s.txb = wr_data;
					nxt_s.take = s_ff.op == SNHA_OP_STATUS_WRITE;
					nxt_s.cnt = (s_ff.op == SNHA_OP_STATUS_WRITE) ? 9'h001 : s_ff.cnt;
					nxt_s.st = S_DATA;
				end else begin
					nxt_s.pend = 1'b0;
					nxt_s.req = s_ff.req;
					nxt_s.cs_n = 1'b1;
					nxt_s.st = S_IDLE;
				end
			end
			S_ADDR: if (ack_ev) begin
				nxt_s.pend = 1'b1;
				nxt_s.req = ~s_ff.req;
				nxt_s.phase_n = s_ff.phase_n + 2'h1;
				if (s_ff.phase_n == 2'h0) begin
					nxt_s.txb = s_ff.addr[15:8];
				end else if (s_ff.phase_n == 2'h1) begin
					nxt_s.txb = s_ff.addr[7:0];
				end else if (s_ff.op == SNHA_OP_FAST_READ && s_ff.phase_n == 2'h2) begin
					nxt_s.txb = 8'h00; // dummy byte
				end else if (s_ff.op == SNHA_OP_ERASE || s_ff.cnt == 9'h000) begin
					nxt_s.pend = 1'b0;
					nxt_s.req = s_ff.req;
					nxt_s.cs_n = 1'b1;
					nxt_s.st = S_POLL;
				end else begin
					nxt_s.txb = wr_data;
					nxt_s.take = is_mod(s_ff.op);
					nxt_s.st = S_DATA;
				end
				if (s_ff.phase_n == 2'h3 && s_ff.op == SNHA_OP_FAST_READ && s_ff.cnt != 9'h000) begin
					nxt_s.txb = 8'h00;
					nxt_s.st = S_DATA;
				end
			end
			S_DATA: if (ack_ev) begin
				nxt_s.rd = lk.rx_byte;
				nxt_s.rdv = !is_mod(s_ff.op);
				nxt_s.cnt = s_ff.cnt - 9'h001;
				if (s_ff.cnt == 9'h001) begin
					nxt_s.cs_n = 1'b1;
					nxt_s.st = is_mod(s_ff.op) ? S_POLL : S_IDLE;
					if (s_ff.op == SNHA_OP_STATUS_READ) begin
						nxt_s.stat = lk.rx_byte;
					end
				end else begin
					nxt_s.pend = 1'b1;
					nxt_s.req = ~s_ff.req;
					nxt_s.txb = is_mod(s_ff.op) ? wr_data : 8'h00;
					nxt_s.take = is_mod(s_ff.op);
				end
			end
			S_POLL: begin
				// self-timed cycle: poll busy until clear or the time runs out
				nxt_s.tmo = is_mod(s_ff.op) ? 32'(cfg_is_flash ? FL_WAIT : EE_WAIT) : 32'h0000_0000;
				nxt_s.cs_n = 1'b0;
				nxt_s.pend = 1'b1;
				nxt_s.req = ~s_ff.req;
				nxt_s.txb = (cfg_is_flash && !cfg_family_b) ? FL_A_STATUS_READ_CMD : EE_STATUS_READ_CMD;
				nxt_s.polled = 1'b0;
				nxt_s.st = S_POLL_RD;
			end
			S_POLL_RD: begin
				if (s_ff.tmo != 32'h0000_0000) begin
					nxt_s.tmo = s_ff.tmo - 32'h0000_0001;
				end
				if (ack_ev) begin
					if (s_ff.polled) begin
						nxt_s.stat = lk.rx_byte;
						nxt_s.cs_n = 1'b1;
						nxt_s.st = S_WAIT;
					end else begin
						nxt_s.polled = 1'b1;
						nxt_s.pend = 1'b1;
						nxt_s.req = ~s_ff.req;
						nxt_s.txb = 8'h00;
					end
				end
			end
			S_WAIT: begin
				if (s_ff.tmo != 32'h0000_0000) begin
					nxt_s.tmo = s_ff.tmo - 32'h0000_0001;
				end
				if (!s_ff.stat[BUSY_IN_PROGRESS_FLAG] || s_ff.tmo == 32'h0000_0000) begin
					nxt_s.st = S_IDLE;
				end else begin
					nxt_s.cs_n = 1'b0;
					nxt_s.pend = 1'b1;
					nxt_s.req = ~s_ff.req;
					nxt_s.txb = (cfg_is_flash && !cfg_family_b) ? FL_A_STATUS_READ_CMD : EE_STATUS_READ_CMD;
					nxt_s.polled = 1'b0;
					nxt_s.st = S_POLL_RD;
				end
			end
			default: nxt_s.st = S_IDLE;
		endcase
		nxt_s.ready = nxt_s.st == S_IDLE && nxt_s.lrst[1];
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff <= '0;
			s_ff.st <= S_IDLE;
			s_ff.op <= SNHA_OP_READ;
			s_ff.cs_n <= 1'b1;
			s_ff.sel <= SEL_RESET[7:0];
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	logic [GPIO_N-1:0] gpio_ff;
	logic sck_o_ff, mosi_o_ff;
	// select on the chosen general-purpose pin, others idle high
	always_ff @(posedge clk) begin
		if (reset) begin
			gpio_ff <= '1;
		end else begin
			for (int i = 0; i < GPIO_N; i++) begin
				gpio_ff[i] <= (8'(i) == s_ff.sel) ? s_ff.cs_n : 1'b1;
			end
		end
	end
	assign gpio_out = gpio_ff;
	// sck runs at just under 4 MHz from the link clock, half period rounded up
	always_ff @(posedge link_clk) begin
		sck_o_ff <= l_sck_ff;
		mosi_o_ff <= l_mosi_ff;
	end
	assign spi_sck = sck_o_ff;
	assign spi_mosi = mosi_o_ff;
	assign cmd_ready = s_ff.ready;
	assign wr_take = s_ff.take;
	assign rd_data = s_ff.rd;
	assign rd_valid = s_ff.rdv;
	assign status_byte = s_ff.stat;
	assign mem_protect = s_ff.stat[PROTECT_ENABLE_BIT];
	assign mem_block_guard = s_ff.stat[BLOCK_GUARD_HI:BLOCK_GUARD_LO];
	assign mem_latch = s_ff.stat[FLASH_WRITE_LATCH];
	assign mem_busy = s_ff.stat[BUSY_IN_PROGRESS_FLAG];
endmodule
`default_nettype wire

/* hw/snha_pkg.sv */
// Functional notes
// - memory reached over SPI master; chip select comes from a general-purpose output pin
// - select pin index comes from a configuration value of the config page
// - SPI mode 0 or mode 3; memory supports both
// - EEPROM read 0x03, write 0x02, each followed by address
// - EEPROM latch set 0x06, clear 0x04, status read 0x05, status write 0x01
// - EEPROM burst at most 256 bytes in a page; wait up to 5 ms after; code caps the burst at 256 bytes whatever the start address
// - EEPROM status: bit7 protect, bits3..2 block guard, bit1 latch, bit0 not ready
// - flash page rewrite opcode 0x58 or 0x0A by vendor family
// - flash status read 0xD7 or 0x05; 0x06, 0x04, 0x01 common
// - flash identity 0x9F, read 0x03, fast read 0x0B
// - flash page program 0x02, page erase 0xDB
// - flash deep sleep 0xB9, wake 0xAB; ultra sleep on one family only; code sends 0x79 for either family
// - allow up to 25 ms for a flash page write
// - flash status: bit7 lock, bits3..2 block guard, bit1 latch, bit0 busy
// - flash page size assumed 256 bytes at initialisation
package snha_pkg;
	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] EE_STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] FL_A_STATUS_READ_CMD = 8'hd7;
	localparam logic [7:0] FL_B_STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] DATA_READ_CMD = 8'h03;
	localparam logic [7:0] DATA_WRITE_CMD = 8'h02;
	localparam logic [7:0] FAST_READ_CMD = 8'h0b;
	localparam logic [7:0] IDENTITY_READ_CMD = 8'h9f;
	localparam logic [7:0] FL_A_PAGE_REWRITE_CMD = 8'h58;
	localparam logic [7:0] FL_B_PAGE_REWRITE_CMD = 8'h0a;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] PAGE_ERASE_CMD = 8'hdb;
	localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
	localparam logic [7:0] ULTRA_SLEEP_CMD = 8'h79;
	localparam logic [7:0] WAKE_FROM_SLEEP_CMD = 8'hab;
	// ****************************************
	// status fields
	// ****************************************
	localparam int PROTECT_ENABLE_BIT = 7;
	localparam int STATUS_LOCK_BIT = 7;
	localparam int BLOCK_GUARD_HI = 3;
	localparam int BLOCK_GUARD_LO = 2;
	localparam int FLASH_WRITE_LATCH = 1;
	localparam int BUSY_IN_PROGRESS_FLAG = 0;
	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int PAGE_BYTES = 256;
	localparam int CLK_HZ = 10_000_000;
	localparam int LINK_HZ = 166_000_000;
	localparam int SCK_HZ = 4_000_000;
	localparam int SCK_HALF_CYC = (LINK_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);
	localparam int EE_WRITE_MS = 5;
	localparam int EE_WRITE_CYC = EE_WRITE_MS * (CLK_HZ / 1000);
	localparam int FL_WRITE_MS = 25;
	localparam int FL_WRITE_CYC = FL_WRITE_MS * (CLK_HZ / 1000);
	localparam int PAGE_READ_US = 85;
	localparam int PAGE_READ_CYC = PAGE_READ_US * (CLK_HZ / 1_000_000);
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;
	// ****************************************
	// operations
	// ****************************************
	typedef enum logic [3:0] {
		SNHA_OP_READ, SNHA_OP_FAST_READ, SNHA_OP_WRITE, SNHA_OP_ERASE, SNHA_OP_REWRITE,
		SNHA_OP_STATUS_READ, SNHA_OP_STATUS_WRITE, SNHA_OP_IDENTITY, SNHA_OP_SLEEP,
		SNHA_OP_ULTRA_SLEEP, SNHA_OP_WAKE, SNHA_OP_LATCH_CLEAR
	} snha_op_t;
endpackage

/* hw/snha_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// handshake between the command side and the link-side shifter
interface snha_link_if;
	logic req_tgl;
	logic [7:0] tx_byte;
	logic last;
	logic cpol;
	logic ack_tgl;
	logic [7:0] rx_byte;
	modport ctl (output req_tgl, tx_byte, last, cpol, input ack_tgl, rx_byte);
	modport phy (input req_tgl, tx_byte, last, cpol, output ack_tgl, rx_byte);
endinterface
`default_nettype wire

/* hw/snha_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
// byte shifter on the link clock; sck derived from link_clk
module snha_shifter
	import snha_pkg::*;
(
	// link clock
	input wire logic link_clk,
	input wire logic link_reset,
	// handshake
	snha_link_if.phy lk,
	// spi pins
	output logic sck,
	output logic mosi,
	input wire logic miso,
	output logic active
);
	typedef struct packed {
		logic [2:0] req_s;
		logic ack;
		logic busy;
		logic phase;
		logic [2:0] bit_n;
		logic [7:0] sh;
		logic [7:0] rx;
		logic sck;
		logic [7:0] div;
	} snha_sh_t;
	snha_sh_t s_ff;
	snha_sh_t nxt_s;

	// ****************************************
	// mode 0 / mode 3 shifting
	// ****************************************
	// low half then high half per bit; both modes sample on rising and shift on falling
	always_comb begin
		nxt_s = s_ff;
		nxt_s.req_s = {s_ff.req_s[1:0], lk.req_tgl};
		if (!s_ff.busy) begin
			nxt_s.sck = lk.cpol;
			if (s_ff.req_s[2] != s_ff.ack && s_ff.req_s[2] == s_ff.req_s[1]) begin
				nxt_s.busy = 1'b1;
				nxt_s.sh = lk.tx_byte;
				nxt_s.bit_n = 3'h0;
				nxt_s.phase = 1'b0;
				nxt_s.div = 8'h00;
			end
		end else if (s_ff.div != 8'(SCK_HALF_CYC - 1)) begin
			nxt_s.div = s_ff.div + 8'h01;
			nxt_s.sck = s_ff.phase;
		end else if (!s_ff.phase) begin
			nxt_s.div = 8'h00;
			nxt_s.sck = 1'b1; // rising edge: sample
			nxt_s.rx = {s_ff.rx[6:0], miso};
			nxt_s.phase = 1'b1;
		end else begin
			nxt_s.div = 8'h00;
			nxt_s.sck = 1'b0; // falling edge: shift
			nxt_s.sh = {s_ff.sh[6:0], 1'b0};
			nxt_s.phase = 1'b0;
			nxt_s.bit_n = s_ff.bit_n + 3'h1;
			if (s_ff.bit_n == 3'h7) begin
				nxt_s.sh = s_ff.sh;
				nxt_s.sck = lk.cpol;
				nxt_s.busy = 1'b0;
				nxt_s.ack = ~s_ff.ack;
			end
		end
	end

	// state register
	always_ff @(posedge link_clk) begin
		if (link_reset) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sck = s_ff.sck;
	assign mosi = s_ff.sh[7];
	assign active = s_ff.busy;
	assign lk.ack_tgl = s_ff.ack;
	assign lk.rx_byte = s_ff.rx;
endmodule
`default_nettype wire

/* testbench/snha_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port-level checks of the memory access block
// ****************************************
module snha_top_properties
	import snha_pkg::*;
#(
	parameter int GPIO_N = 8
) (
	// system clock
	input wire logic clk,
	input wire logic reset,
	// configuration
	input wire logic [7:0] cfg_sel_pin,
	input wire logic cfg_mode3,
	// command side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic wr_take,
	input wire logic rd_valid,
	// status
	input wire logic [7:0] status_byte,
	input wire logic mem_protect,
	input wire logic [1:0] mem_block_guard,
	input wire logic mem_latch,
	input wire logic mem_busy,
	// pins
	input wire logic spi_sck,
	input wire logic [GPIO_N-1:0] gpio_out
);
	logic [9:0] take_cnt_ff;
	logic [9:0] nxt_take_cnt;
	// count data bytes taken within one command
	always_comb begin
		nxt_take_cnt = take_cnt_ff;
		if (cmd_valid && cmd_ready) nxt_take_cnt = 10'h000;
		else if (wr_take && take_cnt_ff != 10'h3ff) nxt_take_cnt = take_cnt_ff + 10'h001;
	end
	always_ff @(posedge clk) begin
		if (reset) take_cnt_ff <= 10'h000;
		else take_cnt_ff <= nxt_take_cnt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// select and idle behaviour
	property p_one_select; $onehot0(~gpio_out); endproperty
	a_one_select: assert property (p_one_select) else $error("several select pins low");
	property p_select_pin; !(&gpio_out) |-> !gpio_out[cfg_sel_pin]; endproperty
	a_select_pin: assert property (p_select_pin) else $error("wrong select pin low");
	property p_reset_idle; disable iff (1'b0) reset |=> (&gpio_out && !cmd_ready); endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
	property p_ready_up; $fell(reset) |-> ##[1:3] cmd_ready; endproperty
	a_ready_up: assert property (p_ready_up) else $error("ready late after reset");
	property p_idle_sck; (cmd_ready && $stable(cfg_mode3)) [*4] |-> spi_sck == cfg_mode3; endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("sck idle level wrong");
	property p_idle_deselect; cmd_ready [*2] |-> &gpio_out; endproperty
	a_idle_deselect: assert property (p_idle_deselect) else $error("memory selected while idle");
	// command sequencing, burst cap and status decode
	property p_take_busy; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
	a_take_busy: assert property (p_take_busy) else $error("ready stayed high after take");
	property p_take_in_cmd; wr_take |-> !cmd_ready; endproperty
	a_take_in_cmd: assert property (p_take_in_cmd) else $error("write byte taken while idle");
	property p_read_in_cmd; rd_valid |-> $past(!cmd_ready); endproperty
	a_read_in_cmd: assert property (p_read_in_cmd) else $error("read byte while idle");
	property p_burst_cap; take_cnt_ff <= 10'h100; endproperty
	a_burst_cap: assert property (p_burst_cap) else $error("burst above one page");
	property p_status_decode;
		mem_busy == status_byte[0] && mem_latch == status_byte[1] &&
			mem_block_guard == status_byte[3:2] && mem_protect == status_byte[7];
	endproperty
	a_status_decode: assert property (p_status_decode) else $error("status fields misdecoded");
	// main scenarios
	c_mode3_take: cover property (cmd_valid && cmd_ready && cfg_mode3);
	c_read: cover property (rd_valid);
	c_full_page: cover property (take_cnt_ff == 10'h100);
endmodule
bind snha_top snha_top_properties #(.GPIO_N(GPIO_N)) u_props (.clk(clk), .reset(reset),
	.cfg_sel_pin(cfg_sel_pin), .cfg_mode3(cfg_mode3), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.wr_take(wr_take), .rd_valid(rd_valid), .status_byte(status_byte), .mem_protect(mem_protect),
	.mem_block_guard(mem_block_guard), .mem_latch(mem_latch), .mem_busy(mem_busy),
	.spi_sck(spi_sck), .gpio_out(gpio_out));
`default_nettype wire

/* testbench/snha_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial memory answering on the spi pins
// ****************************************
module snha_mem_model (
	// spi pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] stat = 8'h8c;
	logic [7:0] op = 8'h00;
	logic [7:0] sh = 8'h00;
	logic [7:0] rb;
	logic hold = 1'b0;
	int n = 0;
	int polls = 0;
	logic [7:0] rxq[$];
	logic [7:0] ops[$];
	// answer byte; status layout with guard bits and protect set, data without wait
	function automatic logic [7:0] resp(input int k);
		if (k == 0) return 8'h00;
		if (op == 8'h05 || op == 8'hd7) return stat;
		return 8'hc0 + 8'(k);
	endfunction
	// frame start puts the first bit out before the first sampling edge
	always @(negedge cs_n) begin
		n = 0;
		miso = 1'b0;
	end
	// sample on the rising edge in both modes, any rate up to 4 MHz
	always @(posedge sck) if (!cs_n) begin
		sh = {sh[6:0], mosi};
		n = n + 1;
		if (n % 8 == 0) rxq.push_back(sh);
		if (n == 8) begin
			op = sh;
			ops.push_back(sh);
			if (sh == 8'h06) stat[1] = 1'b1;
			if (sh == 8'h04) stat[1] = 1'b0;
		end
	end
	// shift out on the falling edge; mode 3 leading edge carries nothing
	always @(negedge sck) if (!cs_n && n > 0) begin
		rb = resp(n / 8);
		miso = rb[7 - n % 8];
	end
	// frame end: self-timed write starts, status polls count it down
	always @(posedge cs_n) begin
		miso = ~miso;
		if (stat[1] && (op == 8'h02 || op == 8'h58 || op == 8'h0a || op == 8'hdb || op == 8'h01)) begin
			stat[1] = 1'b0;
			stat[0] = 1'b1;
			polls = 2;
		end else if ((op == 8'h05 || op == 8'hd7) && n >= 16 && stat[0] && !hold) begin
			polls = polls - 1;
			if (polls == 0) stat[0] = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* testbench/snha_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// command-level bench of the memory access block
// ****************************************
module snha_top_tb_top
	import snha_pkg::*;
;
	logic clk, link_clk, reset, cfg_is_flash, cfg_family_b, cfg_mode3, cmd_valid;
	logic [7:0] cfg_sel_pin, wr_data;
	logic [3:0] cmd_op;
	logic [23:0] cmd_addr;
	logic [8:0] cmd_len;
	wire logic wr_take, rd_valid, cmd_ready, mem_protect, mem_latch, mem_busy, spi_sck, spi_mosi, spi_miso;
	wire logic [7:0] rd_data, status_byte, gpio_out;
	wire logic [1:0] mem_block_guard;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	int nw, dur;
	logic [7:0] rdq[$];
	logic [7:0] ex[$];
	snha_top #(.GPIO_N(8), .EE_WAIT(200), .FL_WAIT(200)) DUT (.clk(clk), .reset(reset), .link_clk(link_clk),
		.cfg_sel_pin(cfg_sel_pin), .cfg_is_flash(cfg_is_flash), .cfg_family_b(cfg_family_b),
		.cfg_mode3(cfg_mode3), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
		.cmd_ready(cmd_ready), .status_byte(status_byte), .mem_protect(mem_protect),
		.mem_block_guard(mem_block_guard), .mem_latch(mem_latch), .mem_busy(mem_busy), .spi_sck(spi_sck),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .gpio_out(gpio_out));
	snha_mem_model u_mem (.cs_n(gpio_out[5]), .sck(spi_sck), .mosi(spi_mosi), .miso(spi_miso));
	// system clock and unrelated link clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one command: wait idle, request for one edge, feed and collect bytes until done
	task automatic run(input logic [3:0] op, input logic [23:0] a, input logic [8:0] n);
		int t;
		t = 0;
		while (cmd_ready !== 1'b1 && t < 9000) begin
			@(posedge clk);
			#1 t++;
		end
		u_mem.rxq.delete();
		u_mem.ops.delete();
		rdq.delete();
		nw = 0;
		wr_data = 8'ha0;
		cmd_op = op;
		cmd_addr = a;
		cmd_len = n;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		t = 0;
		forever begin
			if (rd_valid === 1'b1) rdq.push_back(rd_data);
			if (wr_take === 1'b1) begin
				wr_data = wr_data + 8'h01;
				nw++;
			end
			if (cmd_ready === 1'b1 || t >= 9000) break;
			@(posedge clk);
			#1 t++;
		end
		dur = t;
		if (t >= 9000) check(32'h0000_0000, 32'h0000_0001);
	endtask
	// read three bytes and check header and data
	task automatic rd_chk(input logic fl, input logic [3:0] op, input int hdr, input logic [7:0] code);
		cfg_is_flash = fl;
		cfg_mode3 = fl;
		run(op, 24'h01_0203, 9'h003);
		check(u_mem.rxq[0], code);
		for (int j = 1; j <= 2 + fl; j++) check(u_mem.rxq[j], 8'(24'h01_0203 >> (8 * (2 + fl - j))));
		for (int i = 0; i < 3; i++) check(rdq[i], 8'hc0 + 8'(hdr + i));
	endtask
	// opcode of one operation, latch set first for writes
	task automatic op_chk(input logic fl, input logic fb, input logic [3:0] op, input logic pre, input logic [7:0] code);
		logic [8:0] n;
		n = (code == 8'hb9 || code == 8'hab || code == 8'h79 || code == 8'h04) ? 9'h000 : 9'h001;
		cfg_is_flash = fl;
		cfg_family_b = fb;
		cfg_mode3 = fb;
		run(op, 24'h00_0300, n);
		if (pre) check(u_mem.ops[0], 8'h06);
		check(u_mem.ops[pre], code);
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		reset = 1'b1;
		{cfg_is_flash, cfg_family_b, cfg_mode3, cmd_valid} = 4'h0;
		cfg_sel_pin = 8'h05;
		cmd_op = 4'h0;
		cmd_addr = 24'h00_0000;
		cmd_len = 9'h000;
		wr_data = 8'h00;
		repeat (8) @(posedge clk);
		#1 check(gpio_out, 8'hff);
		check(cmd_ready, 1'b0);
		repeat (8) @(posedge clk);
		#1 reset = 1'b0;
		run(SNHA_OP_WRITE, 24'h00_1234, 9'h002);
		ex = '{8'h06, 8'h02, 8'h12, 8'h34, 8'ha0, 8'ha1};
		foreach (ex[i]) check(u_mem.rxq[i], ex[i]);
		check(u_mem.ops.size(), 5);
		for (int i = 2; i < 5; i++) check(u_mem.ops[i], 8'h05);
		check(nw, 2);
		check(status_byte, 8'h8c);
		check({mem_protect, mem_block_guard, mem_latch, mem_busy}, 5'h1c);
		run(SNHA_OP_WRITE, 24'h00_0100, 9'h12c);
		check(nw, 256);
		rd_chk(1'b0, SNHA_OP_READ, 3, 8'h03);
		rd_chk(1'b1, SNHA_OP_READ, 4, 8'h03);
		rd_chk(1'b1, SNHA_OP_FAST_READ, 5, 8'h0b);
		op_chk(1'b0, 1'b0, SNHA_OP_STATUS_READ, 1'b0, 8'h05);
		op_chk(1'b0, 1'b0, SNHA_OP_LATCH_CLEAR, 1'b0, 8'h04);
		op_chk(1'b0, 1'b0, SNHA_OP_STATUS_WRITE, 1'b1, 8'h01);
		op_chk(1'b1, 1'b0, SNHA_OP_STATUS_READ, 1'b0, 8'hd7);
		op_chk(1'b1, 1'b1, SNHA_OP_STATUS_READ, 1'b0, 8'h05);
		op_chk(1'b1, 1'b1, SNHA_OP_STATUS_WRITE, 1'b1, 8'h01);
		op_chk(1'b1, 1'b1, SNHA_OP_LATCH_CLEAR, 1'b0, 8'h04);
		op_chk(1'b1, 1'b0, SNHA_OP_IDENTITY, 1'b0, 8'h9f);
		op_chk(1'b1, 1'b0, SNHA_OP_REWRITE, 1'b1, 8'h58);
		op_chk(1'b1, 1'b1, SNHA_OP_REWRITE, 1'b1, 8'h0a);
		op_chk(1'b1, 1'b0, SNHA_OP_WRITE, 1'b1, 8'h02);
		op_chk(1'b1, 1'b1, SNHA_OP_ERASE, 1'b1, 8'hdb);
		op_chk(1'b1, 1'b0, SNHA_OP_SLEEP, 1'b0, 8'hb9);
		op_chk(1'b1, 1'b0, SNHA_OP_ULTRA_SLEEP, 1'b0, 8'h79);
		op_chk(1'b1, 1'b0, SNHA_OP_WAKE, 1'b0, 8'hab);
		check(status_byte, 8'h8c);
		// memory stays busy: the write wait must run its full length
		u_mem.hold = 1'b1;
		for (int f = 0; f < 2; f++) begin
			cfg_is_flash = f[0];
			run(SNHA_OP_WRITE, 24'h00_0000, 9'h001);
			check(dur >= 300 && dur < 600, 1'b1);
		end
		finish_test();
	end
endmodule
`default_nettype wire
